// [hdl/shi_host.sv]
// host end: two-wire bus master that generates scl and runs transfers
`timescale 1ns/1ns
`default_nettype none
`include "shi_params.svh"
// What this block does
// RULE1 - idle: both lines released and high
// RULE2 - sda falls while scl high: start
// RULE3 - sda rises while scl high: stop
// RULE4 - sda stable while scl is high
// RULE5 - address byte sent MSB first, eight pulses
// RULE6 - address LSB: zero write, one read
// RULE7 - head acks matching address at ninth pulse
// RULE8 - receiver acks; transmitter releases sda
// RULE9 - master makes every scl pulse
// RULE10 - master nacks final byte it reads
// RULE11 - head releases sda after master nack
// RULE12 - head ignores the general call address
// RULE13 - head address starts at 0x7f
// RULE14 - address register write reprograms head address
// RULE15 - new addresses stay within 0x08 to 0x77
// RULE16 - reserved addresses are never targeted or assigned
// RULE17 - wait 40 ms after a write
// RULE18 - start only on a free bus
// RULE19 - scl no faster than 100 kHz
// RULE20 - head receives and acks written bytes
// RULE21 - first byte after address selects register
// RULE22 - checksum is minus sum minus five
// RULE23 - stop ends transfer; acked data stays valid
// RULE24 - head filters and synchronises scl and sda
module shi_host #(
    parameter int unsigned Q_CYC = `SHI_Q_CYC,
    parameter int unsigned WR_GAP_CYC = `SHI_WR_GAP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    shi_bus_if.master bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire shi_pkg::shi_addr_t cmd_addr,
    input wire logic cmd_rw,
    input wire shi_pkg::shi_byte_t cmd_len,
    input wire shi_pkg::shi_byte_t wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output shi_pkg::shi_byte_t rd_data,
    output logic rd_valid,
    output logic done,
    output logic nacked,
    output logic refused
);
    import shi_pkg::*;

    localparam int unsigned FREE_CYC = 4 * Q_CYC;

    if (Q_CYC < 2 || Q_CYC > 16383) begin : g_bad_q
        $error("shi_host: Q_CYC must be 2..16383");
    end
    if (WR_GAP_CYC < 1) begin : g_bad_gap
        $error("shi_host: WR_GAP_CYC must be at least 1");
    end

    logic [1:0] scl_sy_q;
    logic [1:0] sda_sy_q;
    shi_mst_e st_q;
    logic [1:0] ph_q;
    logic [15:0] qc_q;
    logic [15:0] free_q;
    logic [31:0] gap_q;
    logic tick;
    shi_byte_t sh_q;
    logic [3:0] bit_q;
    logic txd_q;
    logic adr_q;
    logic rw_q;
    logic need_q;
    logic nk_q;
    logic cs_q;
    shi_byte_t rem_q;
    shi_byte_t sum_q;
    shi_byte_t reg_q;
    logic [1:0] widx_q;
    logic scl_low_q;
    logic sda_low_q;
    logic bad_new;
    logic take;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_sy_q <= 2'h3;
            sda_sy_q <= 2'h3;
        end else begin
            scl_sy_q <= {scl_sy_q[0], bus.scl};
            sda_sy_q <= {sda_sy_q[0], bus.sda};
        end
    end

    // quarter-period timer; it stands while a write byte is awaited
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qc_q <= 16'h0000;
        end else if (st_q == SHI_M_IDLE || st_q == SHI_M_BUSW || need_q || tick) begin
            qc_q <= 16'h0000;
        end else begin
            qc_q <= qc_q + 16'h0001;
        end
    end
    assign tick = (qc_q == 16'(Q_CYC - 1)); // RULE19

    // bus-free detector: both lines high for a full bit time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            free_q <= 16'h0000;
        end else if (st_q != SHI_M_BUSW || !(scl_sy_q[1] && sda_sy_q[1])) begin
            free_q <= 16'h0000;
        end else begin
            free_q <= free_q + 16'h0001;
        end
    end

    // settling time after a write before the next transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_q <= 32'h0000_0000;
        end else if (st_q == SHI_M_STOP && tick && ph_q == 2'h3 && !rw_q) begin
            gap_q <= 32'(WR_GAP_CYC); // RULE17
        end else if (gap_q != 32'h0000_0000) begin
            gap_q <= gap_q - 32'h0000_0001;
        end
    end

    assign cmd_ready = (st_q == SHI_M_IDLE) && (gap_q == 32'h0000_0000); // RULE17 RULE18
    assign wr_ready = (st_q == SHI_M_XFER) && need_q;
    assign take = wr_ready && wr_valid;
    assign bad_new = (widx_q == 2'h1) && (reg_q == `SHI_REG_ADDR)
        && (wr_data < `SHI_USE_MIN || wr_data > `SHI_USE_MAX); // RULE15 RULE16

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= SHI_M_IDLE;
            ph_q <= 2'h0;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            txd_q <= 1'b1;
            adr_q <= 1'b1;
            rw_q <= 1'b0;
            need_q <= 1'b0;
            nk_q <= 1'b1;
            cs_q <= 1'b0;
            rem_q <= 8'h00;
            sum_q <= 8'h00;
            reg_q <= 8'h00;
            widx_q <= 2'h0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            done <= 1'b0;
            nacked <= 1'b0;
            refused <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            done <= 1'b0;
            unique case (st_q)
                SHI_M_IDLE: begin
                    scl_low_q <= 1'b0; // RULE1
                    sda_low_q <= 1'b0; // RULE1
                    if (cmd_valid && cmd_ready) begin
                        nacked <= 1'b0;
                        refused <= 1'b0;
                        rw_q <= cmd_rw;
                        rem_q <= cmd_len;
                        sum_q <= `SHI_CS_BIAS;
                        widx_q <= 2'h0;
                        cs_q <= 1'b0;
                        sh_q <= {cmd_addr, cmd_rw}; // RULE5 RULE6
                        if (cmd_addr <= `SHI_RSV_LO_MAX || cmd_len == 8'h00) begin
                            refused <= 1'b1; // RULE16
                            done <= 1'b1;
                        end else begin
                            st_q <= SHI_M_BUSW;
                        end
                    end
                end
                SHI_M_BUSW: begin
                    if (free_q == 16'(FREE_CYC - 1)) begin
                        st_q <= SHI_M_START; // RULE18
                        ph_q <= 2'h0;
                    end
                end
                SHI_M_START: begin
                    if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == 2'h0) sda_low_q <= 1'b1; // RULE2
                        if (ph_q == 2'h3) begin
                            scl_low_q <= 1'b1;
                            st_q <= SHI_M_XFER;
                            bit_q <= 4'h0;
                            txd_q <= 1'b1;
                            adr_q <= 1'b1;
                        end
                    end
                end
                SHI_M_XFER: begin
                    if (need_q) begin
                        if (take) begin
                            need_q <= 1'b0;
                            sh_q <= wr_data;
                            rem_q <= rem_q - 8'h01;
                            sum_q <= sum_q + wr_data; // RULE22
                            if (widx_q == 2'h0) reg_q <= wr_data; // RULE21
                            if (widx_q != 2'h3) widx_q <= widx_q + 2'h1;
                            if (bad_new) begin
                                refused <= 1'b1;
                                st_q <= SHI_M_STOP; // RULE23
                            end
                        end
                    end else if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        unique case (ph_q)
                            2'h0: begin
                                // data changes only in the middle of scl low
                                if (bit_q == 4'h8) begin
                                    sda_low_q <= !txd_q && rem_q != 8'h01; // RULE8 RULE10
                                end else begin
                                    sda_low_q <= txd_q && !sh_q[7]; // RULE4 RULE5
                                end
                            end
                            2'h1: scl_low_q <= 1'b0; // RULE9
                            2'h2: begin
                                if (bit_q == 4'h8) nk_q <= sda_sy_q[1]; // RULE7
                                else if (!txd_q) sh_q <= {sh_q[6:0], sda_sy_q[1]};
                            end
                            2'h3: begin
                                scl_low_q <= 1'b1; // RULE9
                                if (bit_q != 4'h8) begin
                                    bit_q <= bit_q + 4'h1;
                                    if (txd_q) sh_q <= {sh_q[6:0], 1'b0};
                                end else begin
                                    bit_q <= 4'h0;
                                    if (txd_q && nk_q) begin
                                        nacked <= 1'b1;
                                        st_q <= SHI_M_STOP; // RULE23
                                    end else if (!txd_q) begin
                                        rd_data <= sh_q;
                                        rd_valid <= 1'b1;
                                        rem_q <= rem_q - 8'h01;
                                        if (rem_q == 8'h01) st_q <= SHI_M_STOP; // RULE10
                                    end else if (adr_q && rw_q) begin
                                        adr_q <= 1'b0;
                                        txd_q <= 1'b0; // RULE6
                                    end else begin
                                        adr_q <= 1'b0;
                                        if (cs_q) begin
                                            st_q <= SHI_M_STOP;
                                        end else if (rem_q == 8'h00) begin
                                            sh_q <= 8'h00 - sum_q; // RULE22
                                            cs_q <= 1'b1;
                                        end else begin
                                            need_q <= 1'b1; // RULE21
                                        end
                                    end
                                end
                            end
                        endcase
                    end
                end
                SHI_M_STOP: begin
                    if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == 2'h0) sda_low_q <= 1'b1;
                        if (ph_q == 2'h1) scl_low_q <= 1'b0;
                        if (ph_q == 2'h3) begin
                            sda_low_q <= 1'b0; // RULE3
                            done <= 1'b1;
                            st_q <= SHI_M_IDLE;
                        end
                    end
                end
                default: st_q <= SHI_M_IDLE;
            endcase
        end
    end

    assign bus.scl_m_out = 1'b0;
    assign bus.scl_m_oe_n = ~scl_low_q; // RULE9
    assign bus.sda_m_out = 1'b0;
    assign bus.sda_m_oe_n = ~sda_low_q;
endmodule
`default_nettype wire

// [hdl/shi_params.svh]
// shared constants of the sensor head two-wire link
`ifndef SHI_PARAMS_SVH
`define SHI_PARAMS_SVH
`define SHI_ADDR_RST 7'h7f
`define SHI_GCALL 7'h00
`define SHI_RSV_LO_MAX 7'h04
`define SHI_USE_MIN 8'h08
`define SHI_USE_MAX 8'h77
`define SHI_REG_ADDR 8'h0d
`define SHI_CS_BIAS 8'h05
`define SHI_WR_BYTES 4'h6
`define SHI_CLK_HZ 50000000
`define SHI_SCL_MAX_HZ 100000
`define SHI_Q_CYC ((`SHI_CLK_HZ + 4 * `SHI_SCL_MAX_HZ - 1) / (4 * `SHI_SCL_MAX_HZ))
`define SHI_WR_GAP_MS 40
`define SHI_WR_GAP_CYC (`SHI_WR_GAP_MS * (`SHI_CLK_HZ / 1000))
`define SHI_FILT_LEN 3
`endif

// [hdl/shi_pkg.sv]
// types of the sensor head two-wire link
package shi_pkg;
    typedef logic [7:0] shi_byte_t;
    typedef logic [6:0] shi_addr_t;
    typedef enum logic [5:0] {
        SHI_S_IDLE = 6'h01,
        SHI_S_ADDR = 6'h02,
        SHI_S_ACK = 6'h04,
        SHI_S_RX = 6'h08,
        SHI_S_TX = 6'h10,
        SHI_S_TXACK = 6'h20
    } shi_slv_e;
    typedef enum logic [4:0] {
        SHI_M_IDLE = 5'h01,
        SHI_M_BUSW = 5'h02,
        SHI_M_START = 5'h04,
        SHI_M_XFER = 5'h08,
        SHI_M_STOP = 5'h10
    } shi_mst_e;
endpackage

// [hdl/shi_bus_if.sv]
// two-wire bus between host and sensor head, with pull-up resolution
`timescale 1ns/1ns
`default_nettype none
interface shi_bus_if;
    logic scl_m_out;
    logic scl_m_oe_n;
    logic sda_m_out;
    logic sda_m_oe_n;
    logic sda_s_out;
    logic sda_s_oe_n;
    logic scl;
    logic sda;
    // released lines rest high through the pull-ups
    assign scl = scl_m_oe_n | scl_m_out;
    assign sda = (sda_m_oe_n | sda_m_out) & (sda_s_oe_n | sda_s_out);
    modport master (output scl_m_out, scl_m_oe_n, sda_m_out, sda_m_oe_n, input scl, sda);
    modport slave (output sda_s_out, sda_s_oe_n, input scl, sda);
endinterface
`default_nettype wire

// [hdl/shi_dev.sv]
// sensor head end: two-wire slave on the head's own clock
`timescale 1ns/1ns
`default_nettype none
`include "shi_params.svh"
module shi_dev #(
    parameter int unsigned FILT_LEN = `SHI_FILT_LEN
) (
    input wire logic link_clk,
    input wire logic rst,
    shi_bus_if.slave bus,
    input wire shi_pkg::shi_byte_t tx_data,
    output logic tx_take,
    output shi_pkg::shi_byte_t rx_data,
    output logic rx_valid,
    output logic rx_is_reg,
    output logic xfer_end,
    output shi_pkg::shi_addr_t own_addr
);
    import shi_pkg::*;

    if (FILT_LEN < 2 || FILT_LEN > 8) begin : g_bad_filt
        $error("shi_dev: FILT_LEN must be 2..8");
    end

    logic [1:0] scl_sy_q;
    logic [1:0] sda_sy_q;
    logic [FILT_LEN-1:0] scl_h_q;
    logic [FILT_LEN-1:0] sda_h_q;
    logic scl_f_q;
    logic sda_f_q;
    logic scl_p_q;
    logic sda_p_q;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    shi_slv_e st_q;
    logic [3:0] cnt_q;
    shi_byte_t sh_q;
    logic drv_q;
    logic rw_q;
    logic addr_hit;
    logic wr_q;
    logic [3:0] idx_q;
    shi_byte_t sum_q;
    shi_byte_t reg_q;
    shi_addr_t cand_q;
    shi_addr_t own_q;

    // two-flop synchronisers, then a run-length glitch filter
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            scl_sy_q <= 2'h3;
            sda_sy_q <= 2'h3;
        end else begin
            scl_sy_q <= {scl_sy_q[0], bus.scl};
            sda_sy_q <= {sda_sy_q[0], bus.sda};
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            scl_h_q <= '1;
            sda_h_q <= '1;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_h_q <= {scl_h_q[FILT_LEN-2:0], scl_sy_q[1]}; // RULE24
            sda_h_q <= {sda_h_q[FILT_LEN-2:0], sda_sy_q[1]}; // RULE24
            if (&scl_h_q) scl_f_q <= 1'b1;
            else if (~|scl_h_q) scl_f_q <= 1'b0;
            if (&sda_h_q) sda_f_q <= 1'b1;
            else if (~|sda_h_q) sda_f_q <= 1'b0;
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
        end
    end

    assign scl_rise = scl_f_q & ~scl_p_q;
    assign scl_fall = ~scl_f_q & scl_p_q;
    assign start_c = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q; // RULE2
    assign stop_c = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q; // RULE3
    // the general call never matches, even if it were programmed
    assign addr_hit = (sh_q[7:1] == own_q) && (sh_q[7:1] != `SHI_GCALL); // RULE7 RULE12

    // bit sequencing; sda only ever changes right after scl falls
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            st_q <= SHI_S_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            drv_q <= 1'b0;
            rw_q <= 1'b0;
        end else if (start_c) begin
            st_q <= SHI_S_ADDR;
            cnt_q <= 4'h0;
            drv_q <= 1'b0;
        end else if (stop_c) begin
            st_q <= SHI_S_IDLE; // RULE23
            drv_q <= 1'b0; // RULE1
        end else begin
            unique case (st_q)
                SHI_S_IDLE: begin
                end
                SHI_S_ADDR, SHI_S_RX: begin
                    if (scl_rise) begin
                        sh_q <= {sh_q[6:0], sda_f_q};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        cnt_q <= 4'h0;
                        if (st_q == SHI_S_RX || addr_hit) begin
                            drv_q <= 1'b1; // RULE7 RULE20
                            st_q <= SHI_S_ACK;
                            if (st_q == SHI_S_ADDR) rw_q <= sh_q[0]; // RULE6
                        end else begin
                            st_q <= SHI_S_IDLE; // RULE7
                        end
                    end
                end
                SHI_S_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            sh_q <= tx_data;
                            drv_q <= ~tx_data[7]; // RULE4
                            st_q <= SHI_S_TX;
                        end else begin
                            drv_q <= 1'b0;
                            st_q <= SHI_S_RX;
                        end
                    end
                end
                SHI_S_TX: begin
                    if (scl_fall) begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h7) begin
                            drv_q <= 1'b0; // RULE8
                            st_q <= SHI_S_TXACK;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            drv_q <= ~sh_q[6]; // RULE4
                        end
                    end
                end
                SHI_S_TXACK: begin
                    if (scl_rise) st_q <= sda_f_q ? SHI_S_IDLE : SHI_S_ACK; // RULE11
                end
                default: st_q <= SHI_S_IDLE;
            endcase
        end
    end

    // received bytes, checksum and address reprogramming
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            wr_q <= 1'b0;
            idx_q <= 4'h0;
            sum_q <= 8'h00;
            reg_q <= 8'h00;
            cand_q <= `SHI_ADDR_RST;
            own_q <= `SHI_ADDR_RST; // RULE13
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_is_reg <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (stop_c && wr_q && idx_q == `SHI_WR_BYTES && reg_q == `SHI_REG_ADDR
                && sum_q == 8'h00) begin
                own_q <= cand_q; // RULE14 RULE22 RULE23
            end
            if (start_c || stop_c) begin
                wr_q <= 1'b0;
            end else if (scl_fall && cnt_q == 4'h8) begin
                if (st_q == SHI_S_ADDR && addr_hit && !sh_q[0]) begin
                    wr_q <= 1'b1;
                    idx_q <= 4'h0;
                    sum_q <= `SHI_CS_BIAS; // RULE22
                end else if (st_q == SHI_S_RX) begin
                    rx_data <= sh_q;
                    rx_valid <= 1'b1; // RULE20
                    rx_is_reg <= (idx_q == 4'h0); // RULE21
                    sum_q <= sum_q + sh_q; // RULE22
                    if (idx_q != 4'hf) idx_q <= idx_q + 4'h1;
                    if (idx_q == 4'h0) reg_q <= sh_q; // RULE21
                    if (idx_q == 4'h1) cand_q <= sh_q[6:0];
                end
            end
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            tx_take <= 1'b0;
            xfer_end <= 1'b0;
        end else begin
            tx_take <= (st_q == SHI_S_ACK) && scl_fall && rw_q && !start_c && !stop_c;
            xfer_end <= stop_c;
        end
    end

    assign own_addr = own_q;
    assign bus.sda_s_out = 1'b0;
    assign bus.sda_s_oe_n = ~drv_q; // RULE8 RULE11
endmodule
`default_nettype wire

// [tb/shi_link_asserts.sv]
// wire-level checks of the two-wire link
`timescale 1ns/1ns
`default_nettype none
module shi_link_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_m_oe_n,
    input wire logic sda_s_oe_n
);
    logic scl_p_q, sda_p_q, first_q, rd_q, ack_up;
    logic [3:0] bit_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ninth rising scl edge of a byte
    assign ack_up = scl && !scl_p_q && bit_q == 4'h8;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl;
            sda_p_q <= sda;
        end
    end
    // bit count within a byte, restarted by a start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_q <= 4'h0;
            first_q <= 1'b0;
            rd_q <= 1'b0;
        end else if (scl && scl_p_q && sda_p_q && !sda) begin
            bit_q <= 4'h0;
            first_q <= 1'b1;
        end else if (scl && !scl_p_q) begin
            bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
            if (bit_q == 4'h9) first_q <= 1'b0;
            if (first_q && bit_q == 4'h7) rd_q <= sda;
        end
    end
    a_stop_idle: assert property (scl && $rose(sda) |-> (scl && sda) [*8])
        else $error("bus busy after stop");
    a_start_hold: assert property (scl && $fell(sda) |-> scl [*8])
        else $error("scl fell too soon after start");
    a_head_stable: assert property (scl && $past(scl) |-> $stable(sda_s_oe_n))
        else $error("head moved sda while scl high");
    a_scl_high: assert property ($rose(scl) |-> scl [*8])
        else $error("scl high phase too short");
    a_scl_low: assert property ($fell(scl) |-> !scl [*8])
        else $error("scl low phase too short");
    a_tx_release: assert property (ack_up && (first_q || !rd_q) |-> sda_m_oe_n)
        else $error("host held sda in ack slot");
    a_nack_hold: assert property (ack_up && !first_q && rd_q && sda |-> sda_s_oe_n [*8])
        else $error("head drove sda after nack");
    a_write_acked: assert property (ack_up && !first_q && !rd_q |-> !sda)
        else $error("written byte not acked");
    cover property (ack_up && first_q && !sda);
    cover property (ack_up && !first_q && rd_q && sda);
    cover property (scl && $rose(sda));
endmodule
`default_nettype wire

// [tb/sensor_head_i2c_slave_tb.sv]
// bench: host and head ends joined over the two-wire bus
`timescale 1ns/1ns
`default_nettype none
module sensor_head_i2c_slave_tb;
    import shi_pkg::*;
    typedef struct {shi_addr_t a; logic rw; shi_byte_t len; logic nk; logic rf;} shi_row_s;
    localparam int unsigned QC = 60;
    localparam int unsigned GAP = 50;
    logic clk, link_clk, rst, cmd_valid, cmd_ready, cmd_rw, wr_valid, wr_ready;
    logic rd_valid, done, nacked, refused, tx_take, rx_valid, rx_is_reg, xfer_end;
    shi_addr_t cmd_addr, own_addr;
    shi_byte_t cmd_len, wr_data, rd_data, tx_data, rx_data, cs;
    shi_byte_t wbuf[5];
    shi_byte_t rdq[$], rxq[$];
    int wi, n_errors, samples_checked, n, n_reg, n_end;
    shi_row_s rows[4] = '{'{7'h7f, 1'b1, 8'h02, 1'b0, 1'b0}, '{7'h33, 1'b0, 8'h01, 1'b1, 1'b0},
        '{7'h02, 1'b1, 8'h01, 1'b0, 1'b1}, '{7'h7f, 1'b1, 8'h00, 1'b0, 1'b1}};
    shi_bus_if shi_bus_if_i();
    shi_host #(.Q_CYC(QC), .WR_GAP_CYC(GAP)) shi_host_i(.clk, .rst, .bus(shi_bus_if_i),
        .cmd_valid, .cmd_ready, .cmd_addr, .cmd_rw, .cmd_len, .wr_data, .wr_valid, .wr_ready,
        .rd_data, .rd_valid, .done, .nacked, .refused);
    shi_dev shi_dev_i(.link_clk, .rst, .bus(shi_bus_if_i), .tx_data, .tx_take, .rx_data,
        .rx_valid, .rx_is_reg, .xfer_end, .own_addr);
    shi_link_asserts shi_link_asserts_i(.clk, .rst, .scl(shi_bus_if_i.scl),
        .sda(shi_bus_if_i.sda), .sda_m_oe_n(shi_bus_if_i.sda_m_oe_n),
        .sda_s_oe_n(shi_bus_if_i.sda_s_oe_n));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end
    // outputs are picked up mid-cycle, away from the edge that launches them
    always @(negedge clk) if (rd_valid === 1'b1) rdq.push_back(rd_data);
    always @(negedge link_clk) begin
        if (rx_valid === 1'b1) rxq.push_back(rx_data);
        if (rx_valid === 1'b1 && rx_is_reg === 1'b1) n_reg++;
        if (xfer_end === 1'b1) n_end++;
    end
    always @(posedge clk) if (wr_valid && wr_ready) wi <= wi + 1;
    always @(negedge clk) wr_data <= wbuf[wi % 5];
    always @(negedge link_clk) if (tx_take === 1'b1) tx_data <= tx_data + 8'h11;
    task automatic check(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_hi(input logic on_done);
        n = 0;
        while ((on_done ? done : cmd_ready) !== 1'b1) begin
            n++;
            if (n > 30000) begin
                n_errors++;
                stop_test();
            end
            @(negedge clk);
        end
    endtask
    task automatic run(input shi_row_s r);
        rdq.delete();
        rxq.delete();
        n_reg = 0;
        wi = 0;
        tx_data = 8'ha5;
        wait_hi(1'b0);
        cmd_addr = r.a;
        cmd_rw = r.rw;
        cmd_len = r.len;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        wait_hi(1'b1);
        check(nacked === r.nk && refused === r.rf, "command outcome");
        if (r.rw && !r.nk && !r.rf) begin
            check(rdq.size() == r.len, "read count");
            foreach (rdq[i]) check(rdq[i] === 8'ha5 + 8'h11 * i[7:0], "read byte");
        end
        $display("command to %h finished", r.a);
        @(negedge clk);
    endtask
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_addr = 7'h00;
        cmd_rw = 1'b0;
        cmd_len = 8'h00;
        wr_valid = 1'b0;
        wr_data = 8'h00;
        tx_data = 8'ha5;
        wi = 0;
        wbuf = '{8'h0d, 8'h21, 8'h00, 8'h00, 8'h00};
        n_errors = 0;
        samples_checked = 0;
        n_reg = 0;
        n_end = 0;
        repeat (2) @(negedge link_clk);
        @(negedge clk);
        check(own_addr === 7'h7f && cmd_ready === 1'b1, "reset values");
        check(shi_bus_if_i.scl === 1'b1 && shi_bus_if_i.sda === 1'b1, "lines idle");
        rst = 1'b0;
        wr_valid = 1'b1;
        repeat (80) @(negedge clk);
        foreach (rows[i]) run(rows[i]);
        run('{7'h7f, 1'b0, 8'h05, 1'b0, 1'b0});
        cs = 8'h00 - (8'h05 + 8'h0d + 8'h21);
        check(rxq.size() == 6 && rxq[0] === 8'h0d && rxq[5] === cs, "written bytes");
        check(n_reg == 1, "register byte flag");
        n = 0;
        while (cmd_ready !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        check(n > GAP - 8 && n <= GAP, "write gap");
        repeat (40) @(negedge clk);
        check(own_addr === 7'h21, "new address");
        run('{7'h7f, 1'b1, 8'h01, 1'b1, 1'b0});
        run('{7'h21, 1'b1, 8'h01, 1'b0, 1'b0});
        wbuf[1] = 8'h78;
        run('{7'h21, 1'b0, 8'h05, 1'b0, 1'b1});
        wbuf[1] = 8'h22;
        run('{7'h21, 1'b0, 8'h02, 1'b0, 1'b0});
        // the head sees the last stop some link cycles after the host is done
        repeat (100) @(negedge clk);
        check(own_addr === 7'h21 && rxq.size() == 3, "short write");
        check(n_reg == 1, "short write register flag");
        check(n_end == 7, "stops seen by head");
        stop_test();
    end
endmodule
`default_nettype wire
